// ---- rtl/mii_rmii_pin_strap_mux.sv ----
// MAC-side pin mux with reset straps and interrupt registers
`timescale 1ns/1ps
`default_nettype none
`include "mps_regs.svh"
module mii_rmii_pin_strap_mux (
	input wire logic clk,
	input wire logic srst,
	input wire logic rmii_sel,
	input wire logic link_clk,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire mps_pkg::mps_addr_t reg_addr,
	input wire mps_pkg::mps_word_t reg_wdata,
	output mps_pkg::mps_word_t reg_rdata,
	input wire mps_pkg::mps_event_t int_event,
	input wire mps_pkg::mps_nibble_t core_rxd,
	input wire logic core_rx_dv,
	input wire logic core_crs,
	input wire logic core_col,
	input wire logic core_rx_er,
	output mps_pkg::mps_nibble_t core_txd,
	output logic core_tx_valid,
	input wire logic tx_en,
	input wire mps_pkg::mps_nibble_t txd,
	output logic rxd3_out,
	output logic rxd2_out,
	input wire logic rxd1_in,
	output logic rxd1_out,
	output logic rxd1_oe,
	input wire logic rxd0_in,
	output logic rxd0_out,
	output logic rxd0_oe,
	input wire logic rx_dv_in,
	output logic rx_dv_out,
	output logic rx_dv_oe,
	input wire logic rx_er_in,
	output logic rx_er_out,
	output logic rx_er_oe,
	input wire logic col_in,
	output logic col_out,
	output logic col_oe,
	input wire logic crs_in,
	output logic crs_out,
	output logic crs_oe,
	output logic txc_out,
	output logic rxc_out,
	output logic interrupt_out,
	output logic mgmt_address_strap_bit2,
	output logic mode_strap_bit0,
	output logic mode_strap_bit1,
	output logic mode_strap_bit2,
	output logic isolate
);
	import mps_pkg::*;

	logic [11:0] pins_raw;
	logic [11:0] pins_sync;
	logic srst_d_reg;
	logic release_now;
	logic strap_oe_reg;
	logic lclk_prev_reg;
	logic lclk_rise;
	logic lclk_fall;
	mps_word_t basic_control_reg;
	mps_word_t phy_control_two_reg;
	mps_event_t int_status_reg;
	mps_event_t int_status_next;
	mps_event_t int_enable_reg;
	mps_event_t rd_clear;
	logic int_any;
	logic interrupt_out_reg;
	logic [3:0] strap_reg;
	logic addr2_reg;
	mps_word_t rdata_reg;
	mps_nibble_t rxd_reg;
	logic rx_dv_reg;
	logic rx_er_reg;
	logic col_reg;
	logic crs_reg;
	logic txc_reg;
	logic rxc_reg;
	mps_nibble_t core_txd_reg;
	logic core_tx_valid_reg;

	// every pin input, the link clock included, crosses two flops first
	assign pins_raw = {link_clk, tx_en, txd, rxd1_in, rxd0_in, rx_dv_in, rx_er_in, col_in, crs_in};

	mps_sync #(
		.WIDTH(12)
	) u_sync (
		.clk(clk),
		.async_in(pins_raw),
		.sync_out(pins_sync)
	);

	// delayed reset marks the release cycle
	always_ff @(posedge clk) begin
		srst_d_reg <= srst;
	end
	assign release_now = srst_d_reg & ~srst;

	// RL7: pins released during reset
	always_ff @(posedge clk) begin
		if (srst) begin
			strap_oe_reg <= 1'b0;
		end else begin
			strap_oe_reg <= 1'b1;
		end
	end

	// RL19: capture straps on release
	// the synced pins lag two cycles, so they still hold the level seen in reset
	always_ff @(posedge clk) begin
		if (srst) begin
			strap_reg <= 4'h0;
			addr2_reg <= 1'b0;
		end else if (release_now) begin
			// RL1: address bit from RXD1
			addr2_reg <= pins_sync[5];
			// RL3: mode bit 2 from RX_DV
			strap_reg[2] <= pins_sync[3];
			// RL4: isolate from RX_ER
			strap_reg[3] <= pins_sync[2];
			// RL5: mode bit 0 from COL
			strap_reg[0] <= pins_sync[1];
			// RL6: mode bit 1 from CRS
			strap_reg[1] <= pins_sync[0];
		end
	end

	// basic control: software writes, release loads the strapped fields
	always_ff @(posedge clk) begin
		if (srst) begin
			basic_control_reg <= `MPS_RST_BASIC_CONTROL;
		end else if (release_now) begin
			// RL2: duplex from RXD0
			basic_control_reg[`MPS_BIT_DUPLEX] <= pins_sync[4];
			basic_control_reg[`MPS_BIT_ISOLATE] <= pins_sync[2];
		end else if (reg_wr && reg_addr == `MPS_OFF_BASIC_CONTROL) begin
			basic_control_reg <= reg_wdata;
		end
	end

	// phy control two holds the interrupt polarity
	always_ff @(posedge clk) begin
		if (srst) begin
			phy_control_two_reg <= `MPS_RST_PHY_CONTROL_TWO;
		end else if (reg_wr && reg_addr == `MPS_OFF_PHY_CONTROL_TWO) begin
			phy_control_two_reg <= reg_wdata;
		end
	end

	// RL9: sticky status, read clears
	// a new event in the clearing cycle survives the read
	assign rd_clear = (reg_rd && reg_addr == `MPS_OFF_INT_CTRL_STAT) ? 8'hff : 8'h00;
	assign int_status_next = (int_status_reg & ~rd_clear) | int_event;
	always_ff @(posedge clk) begin
		if (srst) begin
			int_status_reg <= mps_event_t'(`MPS_RST_INT_CTRL_STAT);
			int_enable_reg <= mps_event_t'(`MPS_RST_INT_CTRL_STAT >> `MPS_INT_EN_LSB);
		end else begin
			int_status_reg <= int_status_next;
			if (reg_wr && reg_addr == `MPS_OFF_INT_CTRL_STAT) begin
				int_enable_reg <= reg_wdata[15:`MPS_INT_EN_LSB];
			end
		end
	end
	assign int_any = |(int_status_reg & int_enable_reg);

	// RL8: polarity from bit 9
	// reset value is the inactive level of the default active-low setting
	always_ff @(posedge clk) begin
		if (srst) begin
			interrupt_out_reg <= 1'b1;
		end else if (phy_control_two_reg[`MPS_BIT_INT_POLARITY]) begin
			interrupt_out_reg <= int_any;
		end else begin
			interrupt_out_reg <= ~int_any;
		end
	end

	// read data is registered; unmapped offsets read as zero
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`MPS_OFF_BASIC_CONTROL: rdata_reg <= basic_control_reg;
				`MPS_OFF_INT_CTRL_STAT: rdata_reg <= {int_enable_reg, int_status_reg};
				`MPS_OFF_PHY_CONTROL_TWO: rdata_reg <= phy_control_two_reg;
				default: rdata_reg <= 16'h0000;
			endcase
		end
	end

	// edge finder on the synchronised link clock
	// it keeps tracking through reset, so release never shows a false edge
	always_ff @(posedge clk) begin
		lclk_prev_reg <= pins_sync[11];
	end
	assign lclk_rise = pins_sync[11] & ~lclk_prev_reg;
	assign lclk_fall = ~pins_sync[11] & lclk_prev_reg;

	// RL11: MII clocks follow link
	// clock outputs lag the link clock by the two-flop synchroniser delay plus one output register, three clk cycles in all
	always_ff @(posedge clk) begin
		if (srst || rmii_sel) begin
			txc_reg <= 1'b0;
			rxc_reg <= 1'b0;
		end else begin
			txc_reg <= pins_sync[11];
			rxc_reg <= pins_sync[11];
		end
	end

	// receive side launches on the falling edge so the MAC samples mid-bit
	always_ff @(posedge clk) begin
		if (srst) begin
			rxd_reg <= 4'h0;
			rx_dv_reg <= 1'b0;
			rx_er_reg <= 1'b0;
			col_reg <= 1'b0;
			crs_reg <= 1'b0;
		end else if (lclk_fall) begin
			// RL12: error in both modes
			rx_er_reg <= core_rx_er & ~isolate;
			if (rmii_sel) begin
				// RL10: merged carrier and valid
				rx_dv_reg <= (core_crs | core_rx_dv) & ~isolate;
				// RL17: two bits per clock
				// RL14: upper pair held low
				rxd_reg <= (core_crs | core_rx_dv) && !isolate ? {2'b00, core_rxd[1:0]} : 4'h0;
				col_reg <= 1'b0;
				crs_reg <= 1'b0;
			end else begin
				rx_dv_reg <= core_rx_dv & ~isolate;
				// RL16: data only with valid
				rxd_reg <= core_rx_dv && !isolate ? core_rxd : 4'h0;
				// RL15: MII collision and carrier
				col_reg <= core_col & ~isolate;
				crs_reg <= core_crs & ~isolate;
			end
		end
	end

	// RL18: sample data with enable
	// RL13: MAC drives two or four bits
	always_ff @(posedge clk) begin
		if (srst) begin
			core_txd_reg <= 4'h0;
			core_tx_valid_reg <= 1'b0;
		end else if (lclk_rise && pins_sync[10]) begin
			core_txd_reg <= rmii_sel ? {2'b00, pins_sync[7:6]} : pins_sync[9:6];
			core_tx_valid_reg <= 1'b1;
		end else begin
			core_tx_valid_reg <= 1'b0;
		end
	end

	// output wiring
	assign isolate = strap_reg[3];
	assign mgmt_address_strap_bit2 = addr2_reg;
	assign mode_strap_bit0 = strap_reg[0];
	assign mode_strap_bit1 = strap_reg[1];
	assign mode_strap_bit2 = strap_reg[2];
	assign reg_rdata = rdata_reg;
	assign interrupt_out = interrupt_out_reg;
	assign core_txd = core_txd_reg;
	assign core_tx_valid = core_tx_valid_reg;
	assign txc_out = txc_reg;
	assign rxc_out = rxc_reg;
	assign rxd3_out = rxd_reg[3];
	assign rxd2_out = rxd_reg[2];
	assign rxd1_out = rxd_reg[1];
	assign rxd0_out = rxd_reg[0];
	assign rx_dv_out = rx_dv_reg;
	assign rx_er_out = rx_er_reg;
	assign col_out = col_reg;
	assign crs_out = crs_reg;
	assign rxd1_oe = strap_oe_reg;
	assign rxd0_oe = strap_oe_reg;
	assign rx_dv_oe = strap_oe_reg;
	assign rx_er_oe = strap_oe_reg;
	assign col_oe = strap_oe_reg;
	assign crs_oe = strap_oe_reg;

	// strap pins float from one cycle into reset until one cycle after its release
	a_oe_in_reset: assert property (@(posedge clk) srst |=> !strap_oe_reg) // RL7
		else $error("strap pin driven during reset");
	a_oe_after_reset: assert property (@(posedge clk) disable iff (srst)
		!$past(srst) |-> strap_oe_reg) // RL7
		else $error("strap pin not driven after reset");
	a_addr_capture: assert property (@(posedge clk) release_now |=>
		mgmt_address_strap_bit2 == $past(pins_sync[5])) // RL1
		else $error("address strap not captured");
	a_duplex_capture: assert property (@(posedge clk) release_now |=>
		basic_control_reg[8] == $past(pins_sync[4])) // RL2
		else $error("duplex strap not captured");
	a_mode_capture: assert property (@(posedge clk) release_now |=>
		strap_reg == {$past(pins_sync[2]), $past(pins_sync[3]), $past(pins_sync[0]),
		$past(pins_sync[1])}) // RL3 RL4 RL5 RL6
		else $error("mode or isolate strap not captured");
	a_strap_hold: assert property (@(posedge clk) disable iff (srst)
		!release_now |=> $stable(strap_reg) && $stable(addr2_reg)) // RL19
		else $error("strap changed outside reset release");
	a_irq_polarity: assert property (@(posedge clk) disable iff (srst)
		!$past(srst) |-> interrupt_out ==
		($past(phy_control_two_reg[9]) ? $past(int_any) : !$past(int_any))) // RL8
		else $error("interrupt level or polarity wrong");
	a_status_sticky: assert property (@(posedge clk) disable iff (srst)
		(int_event != 8'h00) |=> (int_status_reg & $past(int_event)) == $past(int_event)) // RL9
		else $error("interrupt event lost");
	a_crs_dv_merge: assert property (@(posedge clk) disable iff (srst)
		lclk_fall && rmii_sel && !isolate |=> rx_dv_out == $past(core_crs | core_rx_dv)) // RL10
		else $error("crs_dv not merged");
	a_rmii_upper_low: assert property (@(posedge clk) disable iff (srst)
		lclk_fall && rmii_sel |=> !rxd3_out && !rxd2_out && !col_out && !crs_out) // RL14
		else $error("mii only outputs active in rmii");
	a_tx_ignore: assert property (@(posedge clk) disable iff (srst)
		!(lclk_rise && pins_sync[10]) |=> !core_tx_valid) // RL18
		else $error("transmit data taken without enable");
	a_mii_data_valid: assert property (@(posedge clk) disable iff (srst) // RL16
		lclk_fall && !rmii_sel && !core_rx_dv |=> rxd_reg == 4'h0)
		else $error("receive data shown without valid");
	a_isolate_quiet: assert property (@(posedge clk) disable iff (srst) // RL4
		lclk_fall && isolate |=> rxd_reg == 4'h0 && !rx_dv_out && !rx_er_out && !col_out && !crs_out)
		else $error("receive outputs active while isolated");
endmodule // mii_rmii_pin_strap_mux
`default_nettype wire

// ---- rtl/mps_regs.svh ----
// register offsets, field positions and reset values for the pin and strap mux
// Overview of operation
// RL1: RXD1 strap becomes management address bit 2
// RL2: RXD0 strap loads duplex bit of register 0
// RL3: RX_DV/CRS_DV strap kept as mode strap 2
// RL4: RX_ER strap becomes the isolate setting
// RL5: COL strap kept as mode strap 0
// RL6: CRS strap kept as mode strap 1
// RL7: strap pins input in reset, output otherwise
// RL8: phy_control_two bit 9 sets interrupt polarity
// RL9: interrupt_control_status enables and reports interrupt events
// RL10: RMII merges carrier and valid onto CRS_DV
// RL11: MII drives transmit and receive clocks out
// RL12: receive error driven in both modes
// RL13: MAC drives enable plus four or two bits
// RL14: four receive bits in MII, two in RMII
// RL15: MII drives collision and carrier sense outputs
// RL16: MII receive data valid only with RX_DV
// RL17: RMII sends two bits per reference clock
// RL18: MII ignores transmit data without TX_EN
// RL19: straps captured at reset release, then fixed
`ifndef MPS_REGS_SVH
`define MPS_REGS_SVH

`define MPS_OFF_BASIC_CONTROL 5'h00
`define MPS_OFF_INT_CTRL_STAT 5'h1b
`define MPS_OFF_PHY_CONTROL_TWO 5'h1f

`define MPS_BIT_DUPLEX 8
`define MPS_BIT_ISOLATE 10
`define MPS_BIT_INT_POLARITY 9
`define MPS_INT_EN_LSB 8

`define MPS_RST_BASIC_CONTROL 16'h0000
`define MPS_RST_INT_CTRL_STAT 16'h0000
`define MPS_RST_PHY_CONTROL_TWO 16'h0000

`endif

// ---- rtl/mps_pkg.sv ----
// shared types of the pin and strap mux
package mps_pkg;
	typedef logic [15:0] mps_word_t;
	typedef logic [4:0] mps_addr_t;
	typedef logic [7:0] mps_event_t;
	typedef logic [3:0] mps_nibble_t;
endpackage

// ---- rtl/mps_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module mps_sync #(
	parameter int WIDTH = 12
) (
	input wire logic clk,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	genvar i;
	// no reset: the chain must keep tracking the pins during reset so straps are seen
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_reg;
			logic stable_reg;
			always_ff @(posedge clk) begin
				meta_reg <= async_in[i];
				stable_reg <= meta_reg;
			end
			assign sync_out[i] = stable_reg;
		end
	endgenerate
endmodule // mps_sync
`default_nettype wire

// ---- verif/mps_mac_model.sv ----
// mac-side model: link clock and transmit pins
`timescale 1ns/1ps
`default_nettype none
module mps_mac_model (
	output logic link_clk,
	output logic tx_en,
	output logic [3:0] txd
);
	// link clock runs free, 48 ns period, no phase tie to clk
	initial begin
		link_clk = 1'b0;
		tx_en = 1'b0;
		txd = 4'h0;
		forever #24 link_clk = ~link_clk;
	end
	task automatic send(input logic [3:0] d, input logic en);
		@(negedge link_clk);
		txd = d;
		tx_en = en;
		@(negedge link_clk);
		tx_en = 1'b0;
		// released data shows the inverse so a stale copy cannot pass
		txd = ~d;
	endtask
endmodule // mps_mac_model
`default_nettype wire

// ---- verif/mii_rmii_pin_strap_mux_tb_top.sv ----
// self-checking bench for the pin and strap mux
`timescale 1ns/1ps
`default_nettype none
module mii_rmii_pin_strap_mux_tb_top;
	import mps_pkg::*;
	logic clk, srst, rmii_sel, reg_wr, reg_rd, link_clk, tx_en, core_tx_valid;
	mps_addr_t reg_addr;
	mps_word_t reg_wdata, reg_rdata, rv;
	mps_event_t int_event;
	mps_nibble_t core_rxd, core_txd, txd, tx_last;
	logic dv, cs, cl, er, rxd3, rxd2, txc, rxc, irq, a2, m0, m1, m2, iso;
	logic [5:0] pull;
	wire [5:0] pin, oe, po;
	int num_errors, n_compared, n_tx, n_clk, k;

	// board pulls win only while the device leaves a pin undriven
	assign pin = (oe & po) | (~oe & pull);

	mps_mac_model u_mps_mac_model (.link_clk(link_clk), .tx_en(tx_en), .txd(txd));

	mii_rmii_pin_strap_mux u_mii_rmii_pin_strap_mux (.clk(clk), .srst(srst),
		.rmii_sel(rmii_sel), .link_clk(link_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.int_event(int_event), .core_rxd(core_rxd), .core_rx_dv(dv), .core_crs(cs),
		.core_col(cl), .core_rx_er(er), .core_txd(core_txd), .core_tx_valid(core_tx_valid),
		.tx_en(tx_en), .txd(txd), .rxd3_out(rxd3), .rxd2_out(rxd2),
		.rxd1_in(pin[0]), .rxd1_out(po[0]), .rxd1_oe(oe[0]),
		.rxd0_in(pin[1]), .rxd0_out(po[1]), .rxd0_oe(oe[1]),
		.rx_dv_in(pin[2]), .rx_dv_out(po[2]), .rx_dv_oe(oe[2]),
		.rx_er_in(pin[3]), .rx_er_out(po[3]), .rx_er_oe(oe[3]),
		.col_in(pin[4]), .col_out(po[4]), .col_oe(oe[4]),
		.crs_in(pin[5]), .crs_out(po[5]), .crs_oe(oe[5]),
		.txc_out(txc), .rxc_out(rxc), .interrupt_out(irq),
		.mgmt_address_strap_bit2(a2), .mode_strap_bit0(m0), .mode_strap_bit1(m1),
		.mode_strap_bit2(m2), .isolate(iso));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// transmit takes and clock-out edges, counted as they happen
	// the one-cycle pulse is looked at mid-cycle, away from its launching edge
	always @(negedge clk) begin
		if (core_tx_valid === 1'b1) begin
			n_tx++;
			tx_last = core_txd;
		end
	end
	always @(posedge rxc) n_clk++;
	always @(posedge txc) n_clk++;

	task automatic tally_and_finish;
		if (num_errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wr(input mps_addr_t a, input mps_word_t d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task automatic rdc(input mps_addr_t a, input mps_word_t e);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		chk(reg_rdata, e);
	endtask

	task automatic pulse(input int b);
		@(negedge clk);
		int_event = 8'(1 << b);
		@(negedge clk);
		int_event = 8'h00;
		cyc(3);
	endtask

	task automatic strap_case(input logic [5:0] s);
		@(negedge clk);
		pull = s;
		srst = 1'b1;
		cyc(6);
		chk(16'(oe), 16'h0000);
		srst = 1'b0;
		cyc(2);
		chk(16'(oe), 16'h003f);
		chk(16'({a2, m2, iso, m0, m1}), 16'({s[0], s[2], s[3], s[4], s[5]}));
		rdc(5'h00, {5'h00, s[3], 1'b0, s[1], 8'h00});
		rx_once(s[3]);
		pull = ~s;
		cyc(8);
		chk(16'({a2, m2, iso, m0, m1}), 16'({s[0], s[2], s[3], s[4], s[5]}));
	endtask

	function automatic logic [7:0] exp_rx(input logic m, input logic [3:0] d,
		input logic v0, input logic c, input logic l, input logic e, input logic i);
		logic v;
		v = m ? (v0 | c) : v0;
		if (!v) d = 4'h0;
		if (i) return 8'h00;
		return m ? {2'b00, d[1:0], v, e, 2'b00} : {d, v, e, l, c};
	endfunction

	task automatic rx_once(input logic i);
		int c0;
		@(negedge clk);
		{core_rxd, dv, cs, cl, er} = 8'($urandom);
		c0 = n_clk;
		cyc(40);
		chk(16'({rxd3, rxd2, po[0], po[1], po[2], po[3], po[4], po[5]}),
			16'(exp_rx(rmii_sel, core_rxd, dv, cs, cl, er, i)));
		chk(16'(n_clk - c0 >= 6), 16'(!rmii_sel));
	endtask

	task automatic tx_once(input logic en);
		mps_nibble_t d, m;
		int c0;
		d = 4'($urandom);
		m = rmii_sel ? 4'h3 : 4'hf;
		c0 = n_tx;
		u_mps_mac_model.send(d, en);
		cyc(12);
		chk(16'(n_tx - c0), 16'(en));
		if (en) chk(16'(tx_last), 16'(d & m));
	endtask

	initial begin
		srst = 1'b1;
		rmii_sel = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		int_event = 8'h00;
		{core_rxd, dv, cs, cl, er} = 8'h00;
		pull = 6'h00;
		num_errors = 0;
		n_compared = 0;
		n_tx = 0;
		n_clk = 0;
		void'($urandom(32'hc29a));
		// corner patterns first and last; last leaves isolate off
		for (int i = 0; i < 4; i++) begin
			strap_case(i == 0 ? 6'h3f : (i == 3 ? 6'h00 : 6'($urandom)));
		end
		k = $urandom % 8;
		wr(5'h1b, 16'h0000);
		pulse(k);
		chk(16'(irq), 16'h0001);
		rdc(5'h1b, 16'h0001 << k);
		rdc(5'h1b, 16'h0000);
		wr(5'h1b, 16'h0100 << k);
		pulse(k);
		chk(16'(irq), 16'h0000);
		wr(5'h1f, 16'h0200);
		cyc(3);
		chk(16'(irq), 16'h0001);
		rdc(5'h1f, 16'h0200);
		rdc(5'h1b, 16'h0101 << k);
		cyc(3);
		chk(16'(irq), 16'h0000);
		wr(5'h05, 16'hffff);
		rdc(5'h05, 16'h0000);
		// event and clearing read in one cycle: the event must survive
		@(negedge clk);
		reg_addr = 5'h1b;
		reg_rd = 1'b1;
		int_event = 8'(1 << k);
		@(negedge clk);
		reg_rd = 1'b0;
		int_event = 8'h00;
		chk(reg_rdata, 16'h0100 << k);
		rdc(5'h1b, 16'h0101 << k);
		rv = 16'($urandom);
		wr(5'h00, rv);
		rdc(5'h00, rv);
		for (int m = 0; m < 2; m++) begin
			rmii_sel = m[0];
			repeat (6) rx_once(1'b0);
			tx_once(1'b1);
			tx_once(1'b0);
			tx_once(1'b1);
		end
		tally_and_finish;
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		tally_and_finish;
	end
endmodule // mii_rmii_pin_strap_mux_tb_top
`default_nettype wire
